//--- logic/pbi_irq_top.sv
// What this block does
// - Request word low holds pages one to thirty-two, bit zero first.
// - Request word high holds pages thirty-three to sixty-four.
// - Successful transfer at a page's last dword sets that page's bit.
// - Any set and unmasked page bit raises the secondary interrupt.
// - Forward: drive the legacy pin low, or send an MSI.
// - Reverse: send an assert message, or send an MSI.
// - Writing one to a request bit clears it.
// - Mask zero lets a request through; mask one holds it back.
// - Writing one to primary clear bits 15:0 clears that request.
// - Reading primary clear returns which primary requests are pending.
`timescale 1ns/100ps
`default_nettype none
module pbi_irq_top
  import pbi_pkg::*;
#(
  parameter int PAGE_SHIFT = 12,
  parameter int XFER_AW = PAGE_SHIFT + 7
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [pbi_pkg::REG_AW-1:0] ADDR,
  input wire logic [pbi_pkg::REG_DW-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [pbi_pkg::REG_DW-1:0] RDATA,
  input wire logic XFER_DONE,
  input wire logic XFER_OK,
  input wire logic [XFER_AW-1:0] XFER_ADDR,
  input wire logic [pbi_pkg::PRI_W-1:0] PRI_SET,
  input wire logic REVERSE,
  output logic INTA_L_O,
  output logic INTA_L_OE,
  output logic INTX_ASSERT_MSG,
  output logic INTX_DEASSERT_MSG,
  output logic MSI_REQ,
  output logic IRQ
);
  import pbi_pkg::*;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  function automatic logic at(input logic [REG_AW-1:0] a,
                              input logic [REG_AW-1:0] off);
    return a == off;
  endfunction

  wire wr_req_lo = WR && at(ADDR, OFF_REQ_LO);
  wire wr_req_hi = WR && at(ADDR, OFF_REQ_HI);
  wire wr_msk_lo = WR && at(ADDR, OFF_MSK_LO);
  wire wr_msk_hi = WR && at(ADDR, OFF_MSK_HI);
  wire wr_pri = WR && at(ADDR, OFF_PRI_CLR);
  wire wr_ctrl = WR && at(ADDR, OFF_CTRL);
  wire wr_stat = WR && at(ADDR, OFF_STAT);
  wire wr_imsk = WR && at(ADDR, OFF_IMSK);

  // ----------------------------------------------------------------
  // Orientation strap
  // ----------------------------------------------------------------
  logic rev_s1;
  logic rev_s2;
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      rev_s1 <= 1'b0;
      rev_s2 <= 1'b0;
    end else begin
      rev_s1 <= REVERSE;
      rev_s2 <= rev_s1;
    end
  end

  // ----------------------------------------------------------------
  // Page boundary detect
  // ----------------------------------------------------------------
  // Only the lower half of the window has request bits
  wire [5:0] xfer_page = XFER_ADDR[PAGE_SHIFT+5:PAGE_SHIFT];
  wire xfer_low_half = !XFER_ADDR[PAGE_SHIFT+6];
  wire xfer_last_dw = &XFER_ADDR[PAGE_SHIFT-1:2];
  wire xfer_hit = XFER_DONE && XFER_OK && xfer_last_dw && xfer_low_half;
  wire [PAGE_BITS-1:0] xfer_set =
    xfer_hit ? (64'h1 << xfer_page) : '0;

  // ----------------------------------------------------------------
  // Request banks
  // ----------------------------------------------------------------
  pbi_w1c_if #(.W(PAGE_BITS)) req_if ();
  pbi_w1c_if #(.W(PRI_W)) pri_if ();

  assign req_if.set = xfer_set;
  assign req_if.clr = {wr_req_hi ? WDATA : 32'h0,
                       wr_req_lo ? WDATA : 32'h0};
  assign pri_if.set = PRI_SET;
  assign pri_if.clr = wr_pri ? WDATA[PRI_W-1:0] : '0;

  pbi_w1c_bank #(.W(PAGE_BITS), .RST_VAL({RST_REQ, RST_REQ})) u_req (
    .clk(CLK_SYS),
    .rst(RST),
    .bus(req_if.owner)
  );

  pbi_w1c_bank #(.W(PRI_W), .RST_VAL(RST_PRI)) u_pri (
    .clk(CLK_SYS),
    .rst(RST),
    .bus(pri_if.owner)
  );

  wire [PAGE_BITS-1:0] req_q = req_if.q;
  wire [PRI_W-1:0] pri_q = pri_if.q;

  // ----------------------------------------------------------------
  // Masks, control, status
  // ----------------------------------------------------------------
  logic [31:0] msk_lo;
  logic [31:0] msk_hi;
  logic msi_en;
  logic [STAT_W-1:0] stat;
  logic [STAT_W-1:0] imsk;

  wire [STAT_W-1:0] stat_set = {|PRI_SET, |xfer_set};
  wire [STAT_W-1:0] stat_clr = wr_stat ? WDATA[STAT_W-1:0] : '0;

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      msk_lo <= RST_MSK;
      msk_hi <= RST_MSK;
    end else begin
      if (wr_msk_lo) msk_lo <= WDATA;
      if (wr_msk_hi) msk_hi <= WDATA;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      msi_en <= 1'b0;
      imsk <= RST_IMSK;
      stat <= '0;
      IRQ <= 1'b0;
    end else begin
      if (wr_ctrl) msi_en <= WDATA[CTRL_MSI_EN];
      if (wr_imsk) imsk <= WDATA[STAT_W-1:0];
      stat <= (stat & ~stat_clr) | stat_set;
      IRQ <= |(stat & ~imsk);
    end
  end

  // ----------------------------------------------------------------
  // Secondary interrupt signalling
  // ----------------------------------------------------------------
  wire [PAGE_BITS-1:0] unmasked = req_q & ~{msk_hi, msk_lo};
  wire pending = |unmasked;

  pbi_sec_state_t state;
  pbi_sec_state_t next_state;
  logic used_pin;
  logic used_msg;
  logic next_used_pin;
  logic next_used_msg;
  logic next_assert;
  logic next_deassert;
  logic next_msi;

  // Mode is latched at assertion so the release matches how it was raised
  always_comb begin
    next_state = state;
    next_used_pin = used_pin;
    next_used_msg = used_msg;
    next_assert = 1'b0;
    next_deassert = 1'b0;
    next_msi = 1'b0;
    case (state)
      PBI_SEC_IDLE: begin
        if (pending) begin
          next_state = PBI_SEC_ASSERTED;
          next_msi = msi_en;
          next_used_pin = !msi_en && !rev_s2;
          next_used_msg = !msi_en && rev_s2;
          next_assert = !msi_en && rev_s2;
        end
      end
      PBI_SEC_ASSERTED: begin
        if (!pending) begin
          next_state = PBI_SEC_IDLE;
          next_deassert = used_msg;
          next_used_pin = 1'b0;
          next_used_msg = 1'b0;
        end
      end
      default: begin
        next_state = PBI_SEC_IDLE;
        next_used_pin = 1'b0;
        next_used_msg = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      state <= PBI_SEC_IDLE;
      used_pin <= 1'b0;
      used_msg <= 1'b0;
      INTA_L_OE <= 1'b0;
      INTX_ASSERT_MSG <= 1'b0;
      INTX_DEASSERT_MSG <= 1'b0;
      MSI_REQ <= 1'b0;
    end else begin
      state <= next_state;
      used_pin <= next_used_pin;
      used_msg <= next_used_msg;
      INTA_L_OE <= next_used_pin;
      INTX_ASSERT_MSG <= next_assert;
      INTX_DEASSERT_MSG <= next_deassert;
      MSI_REQ <= next_msi;
    end
  end

  // Open drain: the pin is only ever pulled low
  assign INTA_L_O = 1'b0;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  wire [31:0] rd_mux =
    at(ADDR, OFF_REQ_LO) ? req_q[31:0] :
    at(ADDR, OFF_REQ_HI) ? req_q[63:32] :
    at(ADDR, OFF_MSK_LO) ? msk_lo :
    at(ADDR, OFF_MSK_HI) ? msk_hi :
    at(ADDR, OFF_PRI_CLR) ? {16'h0000, pri_q} :
    at(ADDR, OFF_CTRL) ? {30'h0, rev_s2, msi_en} :
    at(ADDR, OFF_STAT) ? {30'h0, stat} :
    at(ADDR, OFF_IMSK) ? {30'h0, imsk} : 32'h0;

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      RDATA <= 32'h0;
    end else begin
      RDATA <= RD ? rd_mux : 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_PAGE_ONE: assert property (@(posedge CLK_SYS) disable iff (RST)
    (xfer_hit && xfer_page == 6'h00) |=> req_q[0])
    else $error("page one did not set bit zero");
  AST_PAGE_33: assert property (@(posedge CLK_SYS) disable iff (RST)
    (xfer_hit && xfer_page == 6'h20) |=> req_q[32])
    else $error("page 33 did not set high word bit zero");
  AST_NO_SET_MIDPAGE: assert property (@(posedge CLK_SYS)
    disable iff (RST)
    (XFER_DONE && !xfer_last_dw && !WR && req_q == '0) |=> req_q == '0)
    else $error("request set by a non-final dword");
  AST_RAISE: assert property (@(posedge CLK_SYS) disable iff (RST)
    (state == PBI_SEC_IDLE && pending) |=> state == PBI_SEC_ASSERTED)
    else $error("pending request not raised");
  AST_FWD_PIN: assert property (@(posedge CLK_SYS) disable iff (RST)
    (state == PBI_SEC_IDLE && pending && !msi_en && !rev_s2)
      |=> INTA_L_OE && !MSI_REQ)
    else $error("forward legacy pin not driven");
  AST_REV_MSG: assert property (@(posedge CLK_SYS) disable iff (RST)
    (state == PBI_SEC_IDLE && pending && !msi_en && rev_s2)
      |=> INTX_ASSERT_MSG ##1 !INTX_ASSERT_MSG)
    else $error("reverse assert message not a single pulse");
  AST_MSI: assert property (@(posedge CLK_SYS) disable iff (RST)
    (state == PBI_SEC_IDLE && pending && msi_en)
      |=> MSI_REQ && !INTA_L_OE && !INTX_ASSERT_MSG)
    else $error("MSI not issued");
  AST_MASK_ALL: assert property (@(posedge CLK_SYS) disable iff (RST)
    (msk_lo == 32'hffff_ffff && msk_hi == 32'hffff_ffff) |-> !pending)
    else $error("masked request raised interrupt");
  AST_PRI_CLR: assert property (@(posedge CLK_SYS) disable iff (RST)
    (wr_pri && PRI_SET == '0) |=> ((pri_q & $past(WDATA[15:0])) == '0))
    else $error("primary request not cleared");
  AST_PRI_READ: assert property (@(posedge CLK_SYS) disable iff (RST)
    (RD && at(ADDR, OFF_PRI_CLR)) |=> RDATA == {16'h0000, $past(pri_q)})
    else $error("primary clear read wrong");
  AST_MASK_RW: assert property (@(posedge CLK_SYS) disable iff (RST)
    wr_msk_lo |=> msk_lo == $past(WDATA))
    else $error("mask word did not keep written value");
  AST_DROP: assert property (@(posedge CLK_SYS) disable iff (RST)
    (state == PBI_SEC_ASSERTED && !pending)
      |=> state == PBI_SEC_IDLE && !INTA_L_OE)
    else $error("interrupt held with nothing pending");
  AST_PAGE_32: assert property (@(posedge CLK_SYS) disable iff (RST)
    (xfer_hit && xfer_page == 6'h1f) |=> req_q[31])
    else $error("page 32 did not set low word top bit");
  AST_PAGE_64: assert property (@(posedge CLK_SYS) disable iff (RST)
    (xfer_hit && xfer_page == 6'h3f) |=> req_q[63])
    else $error("page 64 did not set high word top bit");
  AST_UPPER_OFF: assert property (@(posedge CLK_SYS) disable iff (RST)
    (XFER_DONE && XFER_ADDR[PAGE_SHIFT+6] && req_q == '0) |=> req_q == '0)
    else $error("upper half transfer set a request");
  AST_IDLE_QUIET: assert property (@(posedge CLK_SYS) disable iff (RST)
    (state == PBI_SEC_IDLE && !pending)
      |=> !INTA_L_OE && !MSI_REQ && !INTX_ASSERT_MSG)
    else $error("interrupt signalled with nothing unmasked");
  AST_REV_OFF: assert property (@(posedge CLK_SYS) disable iff (RST)
    (state == PBI_SEC_ASSERTED && !pending && used_msg)
      |=> INTX_DEASSERT_MSG)
    else $error("deassert message missing after message assertion");
  AST_MASK_RW_HI: assert property (@(posedge CLK_SYS) disable iff (RST)
    wr_msk_hi |=> msk_hi == $past(WDATA))
    else $error("high mask word did not keep written value");
endmodule
`default_nettype wire

//--- include/pbi_pkg.sv
`default_nettype none
package pbi_pkg;
  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  localparam int REG_AW = 8;
  localparam int REG_DW = 32;
  localparam logic [REG_AW-1:0] OFF_REQ_LO = 8'h58;
  localparam logic [REG_AW-1:0] OFF_REQ_HI = 8'h5c;
  localparam logic [REG_AW-1:0] OFF_MSK_LO = 8'h60;
  localparam logic [REG_AW-1:0] OFF_MSK_HI = 8'h64;
  localparam logic [REG_AW-1:0] OFF_PRI_CLR = 8'h70;
  localparam logic [REG_AW-1:0] OFF_CTRL = 8'h80;
  localparam logic [REG_AW-1:0] OFF_STAT = 8'h84;
  localparam logic [REG_AW-1:0] OFF_IMSK = 8'h88;
  // ----------------------------------------------------------------
  // Widths, fields and reset values
  // ----------------------------------------------------------------
  localparam int PAGE_BITS = 64;
  localparam int PRI_W = 16;
  localparam int STAT_W = 2;
  localparam int CTRL_MSI_EN = 0;
  localparam int CTRL_REVERSE = 1;
  localparam int STAT_PAGE = 0;
  localparam int STAT_PRI = 1;
  localparam logic [31:0] RST_REQ = 32'h0000_0000;
  localparam logic [31:0] RST_MSK = 32'h0fff_ffff;
  localparam logic [15:0] RST_PRI = 16'h0000;
  localparam logic [1:0] RST_IMSK = 2'h3;
  // ----------------------------------------------------------------
  // Secondary signalling states
  // ----------------------------------------------------------------
  typedef enum logic {PBI_SEC_IDLE, PBI_SEC_ASSERTED} pbi_sec_state_t;
endpackage
`default_nettype wire

//--- include/pbi_w1c_if.sv
`timescale 1ns/100ps
`default_nettype none
interface pbi_w1c_if #(parameter int W = 16);
  logic [W-1:0] set;
  logic [W-1:0] clr;
  logic [W-1:0] q;
  modport owner (input set, input clr, output q);
  modport user (output set, output clr, input q);
endinterface
`default_nettype wire

//--- logic/pbi_w1c_bank.sv
`timescale 1ns/100ps
`default_nettype none
module pbi_w1c_bank #(
  parameter int W = 16,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  pbi_w1c_if.owner bus
);
  logic [W-1:0] bits;
  logic [W-1:0] next_bits;

  // Set beats clear so an event racing a clear is never lost
  assign next_bits = (bits & ~bus.clr) | bus.set;
  assign bus.q = bits;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bits <= RST_VAL;
    end else begin
      bits <= next_bits;
    end
  end

  AST_SET_WINS: assert property (@(posedge clk) disable iff (rst)
    (|bus.set) |=> ((bits & $past(bus.set)) == $past(bus.set)))
    else $error("set bit not held after set");
  AST_CLR_ONE: assert property (@(posedge clk) disable iff (rst)
    ((bus.set & bus.clr) == '0 && (|bus.clr))
      |=> ((bits & $past(bus.clr)) == '0))
    else $error("written one did not clear bit");
  AST_CLR_ZERO: assert property (@(posedge clk) disable iff (rst)
    (bus.set == '0) |=> (bits == ($past(bits) & ~$past(bus.clr))))
    else $error("bit changed without a set or a written one");
endmodule
`default_nettype wire

//--- tb/pbi_sec_model.sv
`timescale 1ns/100ps
`default_nettype none
module pbi_sec_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin_oe,
  input wire logic msg_on,
  input wire logic msg_off,
  input wire logic msi,
  output logic seen,
  output logic [7:0] msi_cnt
);
  // ----------------------------------------------------------------
  // Secondary host view of the page interrupt
  // ----------------------------------------------------------------
  logic msg_state;
  // Host sees the wired pin or the virtual wire, whichever is in use
  assign seen = pin_oe | msg_state;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      msg_state <= 1'b0;
      msi_cnt <= 8'h00;
    end else begin
      if (msg_on) msg_state <= 1'b1;
      if (msg_off) msg_state <= 1'b0;
      // MSI is an edge event; the host only counts them
      if (msi) msi_cnt <= msi_cnt + 8'h01;
    end
  end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    checks_done++; \
    if ((g) !== (e)) begin \
      mismatches++; \
      $display("mismatch %s exp %h got %h", nm, e, g); \
    end \
  end
module tb_top;
  import pbi_pkg::*;
  localparam int PS = 12;
  localparam int AW = PS + 7;
  logic clk_sys, rst, wr, rd, xfer_done, xfer_ok, reverse;
  logic [REG_AW-1:0] addr;
  logic [REG_DW-1:0] wdata, rdata, rv, d;
  logic [AW-1:0] xfer_addr;
  logic [PRI_W-1:0] pri_set, exp_pri;
  logic inta_o, inta_oe, msg_on, msg_off, msi, irq, seen;
  logic [7:0] msi_cnt;
  logic [63:0] exp_req;
  int mismatches, checks_done, cycles, pg, k;
  logic [7:0] offs [6] = '{8'h58, 8'h5c, 8'h60, 8'h64, 8'h70, 8'h90};
  logic [31:0] rvals [6] = '{32'h0, 32'h0, 32'h0fffffff, 32'h0fffffff,
                             32'h0, 32'h0};
  pbi_irq_top #(.PAGE_SHIFT(PS)) pbi_irq_top_i (.CLK_SYS(clk_sys),
    .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .XFER_DONE(xfer_done), .XFER_OK(xfer_ok),
    .XFER_ADDR(xfer_addr), .PRI_SET(pri_set), .REVERSE(reverse),
    .INTA_L_O(inta_o), .INTA_L_OE(inta_oe), .INTX_ASSERT_MSG(msg_on),
    .INTX_DEASSERT_MSG(msg_off), .MSI_REQ(msi), .IRQ(irq));
  pbi_sec_model pbi_sec_model_i (.clk(clk_sys), .rst(rst),
    .pin_oe(inta_oe), .msg_on(msg_on), .msg_off(msg_off), .msi(msi),
    .seen(seen), .msi_cnt(msi_cnt));
  always #10 clk_sys = ~clk_sys;
  // ----------------------------------------------------------------
  // Bus and event drivers
  // ----------------------------------------------------------------
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    @(negedge clk_sys);
    rv = rdata;
    `CHK("rdata", e, rv)
  endtask
  // Window offset: upper half bit, page index, then offset in page
  function automatic logic [AW-1:0] xa(int p, bit last, bit up);
    logic [AW-1:0] lo;
    lo = last ? AW'((1 << PS) - 4 + $urandom_range(3, 0))
              : AW'($urandom_range((1 << PS) - 5, 0));
    return (AW'(up) << (PS + 6)) | (AW'(p & 63) << PS) | lo;
  endfunction
  task automatic hit(int p, bit ok, bit last, bit up);
    @(posedge clk_sys);
    xfer_done <= 1'b1;
    xfer_ok <= ok;
    xfer_addr <= xa(p, last, up);
    @(posedge clk_sys);
    xfer_done <= 1'b0;
    if (ok && last && !up) exp_req[p] = 1'b1;
  endtask
  task automatic settle();
    // Message and MSI reach the host model one edge after the pin
    repeat (3) @(negedge clk_sys);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      complete_run();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    rst = 1'b1;
    {wr, rd, xfer_done, xfer_ok, reverse} = '0;
    addr = '0;
    wdata = '0;
    xfer_addr = '0;
    pri_set = '0;
    exp_req = '0;
    void'($urandom(62));
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    for (k = 0; k < 6; k++) chk_rd(offs[k], rvals[k]);
    `CHK("seen", 1'b0, seen)
    $display("test reset done");
    for (k = 0; k < 2; k++) begin
      d = $urandom;
      wr_reg(8'h60 + 8'(4 * k), d);
      chk_rd(8'h60 + 8'(4 * k), d);
      wr_reg(8'h60 + 8'(4 * k), 32'hffffffff);
    end
    $display("test masks done");
    repeat (12) begin
      pg = $urandom_range(63, 0);
      k = $urandom_range(3, 0);
      hit(pg, k != 1, k != 2, k == 3);
    end
    for (k = 0; k < 4; k++) hit(32 * (k >> 1) + 31 * (k & 1), 1, 1, 0);
    chk_rd(8'h58, exp_req[31:0]);
    chk_rd(8'h5c, exp_req[63:32]);
    `CHK("seen", 1'b0, seen)
    $display("test events done");
    wr_reg(8'h60, 32'h7fffffff);
    settle();
    `CHK("pin_oe", 1'b1, inta_oe)
    `CHK("pin_o", 1'b0, inta_o)
    wr_reg(8'h58, 32'h0);
    chk_rd(8'h58, exp_req[31:0]);
    wr_reg(8'h58, 32'h80000000);
    exp_req[31] = 1'b0;
    chk_rd(8'h58, exp_req[31:0]);
    `CHK("seen", 1'b0, seen)
    $display("test pin done");
    @(posedge clk_sys);
    reverse <= 1'b1;
    repeat (3) @(posedge clk_sys);
    wr_reg(8'h64, 32'hfffffffe);
    settle();
    `CHK("seen", 1'b1, seen)
    `CHK("pin_oe", 1'b0, inta_oe)
    wr_reg(8'h5c, 32'h1);
    exp_req[32] = 1'b0;
    settle();
    `CHK("seen", 1'b0, seen)
    $display("test message done");
    wr_reg(OFF_CTRL, 32'h1);
    wr_reg(8'h64, 32'h7fffffff);
    settle();
    `CHK("msi", 8'h01, msi_cnt)
    wr_reg(8'h5c, 32'h80000000);
    hit(63, 1, 1, 0);
    settle();
    `CHK("msi", 8'h02, msi_cnt)
    wr_reg(8'h64, 32'hffffffff);
    $display("test msi done");
    exp_pri = 16'($urandom) | 16'h0001;
    @(posedge clk_sys);
    pri_set <= exp_pri;
    @(posedge clk_sys);
    pri_set <= '0;
    chk_rd(8'h70, {16'h0, exp_pri});
    d = $urandom;
    wr_reg(8'h70, d);
    exp_pri &= ~d[15:0];
    chk_rd(8'h70, {16'h0, exp_pri});
    chk_rd(OFF_STAT, 32'h3);
    wr_reg(OFF_IMSK, 32'h0);
    settle();
    `CHK("irq", 1'b1, irq)
    wr_reg(OFF_STAT, 32'h3);
    settle();
    `CHK("irq", 1'b0, irq)
    $display("test primary done");
    complete_run();
  end
endmodule
`default_nettype wire
